// *** rtl/pwmet_pkg.sv ***
package pwmet_pkg;
  // =====================================================
  // Widths
  localparam int CW  = 14;
  localparam int FW  = 4;
  localparam int EW  = CW + FW;
  localparam int AJW = 16;
  localparam int QSH = 2;
  localparam int SW  = CW - QSH;
  localparam int DW  = 32;
  // =====================================================
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PER  = 8'h04;
  localparam logic [7:0] A_EV1  = 8'h08;
  localparam logic [7:0] A_EV2  = 8'h0C;
  localparam logic [7:0] A_EV3  = 8'h10;
  localparam logic [7:0] A_EV4  = 8'h14;
  localparam logic [7:0] A_ADJA = 8'h18;
  localparam logic [7:0] A_ADJB = 8'h1C;
  localparam logic [7:0] A_SMP1 = 8'h20;
  localparam logic [7:0] A_SMP2 = 8'h24;
  localparam logic [7:0] A_PHS  = 8'h28;
  localparam logic [7:0] A_BAB  = 8'h2C;
  localparam logic [7:0] A_BAE  = 8'h30;
  localparam logic [7:0] A_BBB  = 8'h34;
  localparam logic [7:0] A_BBE  = 8'h38;
  localparam logic [7:0] A_THU  = 8'h3C;
  localparam logic [7:0] A_THL  = 8'h40;
  localparam logic [7:0] A_STAT = 8'h44;
  // =====================================================
  // Control fields and reset values
  localparam int B_EN   = 0;
  localparam int B_OPEN = 1;
  localparam int B_OS   = 2;
  localparam int B_DIV  = 4;
  localparam int B_AUTO = 8;
  localparam int B_CLIM = 9;
  localparam int B_BMAT = 10;
  localparam logic [10:0] RST_CTRL = 11'h002;
  localparam logic [CW-1:0] RST_PER = 14'h00FF;
  // =====================================================
  // Modes
  typedef enum logic [1:0] {
    PWMET_PWM = 2'b01,
    PWMET_PSH = 2'b10
  } pwmet_mode_t;
  // =====================================================
  // Interrupt divide table, setting 0 disables
  function automatic logic [7:0] div_count(input logic [3:0] s);
    case (s)
      4'h1:    div_count = 8'h00;
      4'h2:    div_count = 8'h01;
      4'h3:    div_count = 8'h03;
      4'h4:    div_count = 8'h07;
      4'h5:    div_count = 8'h0F;
      4'h6:    div_count = 8'h1F;
      4'h7:    div_count = 8'h2F;
      4'h8:    div_count = 8'h3F;
      4'h9:    div_count = 8'h4F;
      4'hA:    div_count = 8'h5F;
      4'hB:    div_count = 8'h7F;
      4'hC:    div_count = 8'h9F;
      4'hD:    div_count = 8'hBF;
      4'hE:    div_count = 8'hDF;
      4'hF:    div_count = 8'hFF;
      default: div_count = 8'h00;
    endcase
  endfunction : div_count
endpackage : pwmet_pkg

// *** rtl/pwmet_engine.sv ***
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// =====================================================
module pwmet_engine (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [17:0] i_filter_duty,
  input  wire logic        i_sync_in,
  input  wire logic        i_clim,
  output logic             o_output_a,
  output logic             o_output_b,
  output logic      [3:0]  o_a_fall_fine,
  output logic      [3:0]  o_b_rise_fine,
  output logic      [3:0]  o_b_fall_fine,
  output logic             o_sync_out,
  output logic             o_error_adc_trig,
  output logic             o_smp2_trig,
  output logic             o_blank_a,
  output logic             o_blank_b,
  output logic             o_period_irq,
  output logic             o_gadc_trig,
  output logic      [1:0]  o_mode
);
  localparam int CW  = pwmet_pkg::CW;
  localparam int EW  = pwmet_pkg::EW;
  localparam int FW  = pwmet_pkg::FW;
  localparam int AJW = pwmet_pkg::AJW;
  localparam int SW  = pwmet_pkg::SW;
  logic [10:0]    ctrl_r;
  logic [CW-1:0]  per_r, per_sh, cnt_r, ev1_r, ev1_sh;
  logic [EW-1:0]  ev2_r, ev3_r, ev4_r, ev2_sh, ev3_sh, ev4_sh;
  logic [AJW-1:0] adja_r, adjb_r, adja_sh, adjb_sh;
  logic [SW-1:0]  smp1_r, smp2_r;
  logic [CW-1:0]  phs_r, bab_r, bae_r, bbb_r, bbe_r, phs_sh;
  logic [EW-1:0]  thu_r, thl_r;
  logic           ack_r;
  logic [31:0]    rdata_r;
  logic           sync_s1, sync_s2, sync_s3, clim_s1, clim_s2;
  logic           en, ld, per_end, sync_rise, clim_trip;
  logic [EW-1:0]  ev2_eff, a_fall, b_fall;
  logic [CW-1:0]  phs_eff, b_fall_c, a_wid_r;
  logic           trunc_r;
  logic [CW-1:0]  nxt_smp_r, os_step;
  logic [3:0]     os_left_r;
  logic           os_hit;
  logic [7:0]     div_r;
  pwmet_pkg::pwmet_mode_t mode_r;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  function automatic logic [EW-1:0] add_adj(input logic [EW-1:0] e,
                                            input logic [AJW-1:0] a);
    add_adj = e + {{(EW-AJW){a[AJW-1]}}, a};
  endfunction : add_adj
  function automatic logic [CW-1:0] q2f(input logic [SW-1:0] s);
    q2f = {s, {pwmet_pkg::QSH{1'b0}}};
  endfunction : q2f

  // =====================================================
  // Bus slave: one wait state on every access
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_readdata    = rdata_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_r) begin
      case (i_avs_address)
        pwmet_pkg::A_CTRL: rdata_r <= 32'(ctrl_r);
        pwmet_pkg::A_PER:  rdata_r <= 32'(per_r);
        pwmet_pkg::A_EV1:  rdata_r <= 32'(ev1_r);
        pwmet_pkg::A_EV2:  rdata_r <= 32'(ev2_r);
        pwmet_pkg::A_EV3:  rdata_r <= 32'(ev3_r);
        pwmet_pkg::A_EV4:  rdata_r <= 32'(ev4_r);
        pwmet_pkg::A_ADJA: rdata_r <= 32'(adja_r);
        pwmet_pkg::A_ADJB: rdata_r <= 32'(adjb_r);
        pwmet_pkg::A_SMP1: rdata_r <= 32'(smp1_r);
        pwmet_pkg::A_SMP2: rdata_r <= 32'(smp2_r);
        pwmet_pkg::A_PHS:  rdata_r <= 32'(phs_r);
        pwmet_pkg::A_BAB:  rdata_r <= 32'(bab_r);
        pwmet_pkg::A_BAE:  rdata_r <= 32'(bae_r);
        pwmet_pkg::A_BBB:  rdata_r <= 32'(bbb_r);
        pwmet_pkg::A_BBE:  rdata_r <= 32'(bbe_r);
        pwmet_pkg::A_THU:  rdata_r <= 32'(thu_r);
        pwmet_pkg::A_THL:  rdata_r <= 32'(thl_r);
        pwmet_pkg::A_STAT: rdata_r <= 32'({mode_r, trunc_r, o_output_a,
                                           o_output_b, cnt_r});
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctrl_r <= pwmet_pkg::RST_CTRL;
      per_r  <= pwmet_pkg::RST_PER;
      {ev1_r, ev2_r, ev3_r, ev4_r, adja_r, adjb_r} <= '0;
      {smp1_r, smp2_r, phs_r, bab_r, bae_r, bbb_r, bbe_r} <= '0;
      {thu_r, thl_r} <= '0;
    end else if (i_avs_write & ack_r) begin
      case (i_avs_address)
        pwmet_pkg::A_CTRL: ctrl_r <= i_avs_writedata[10:0];
        pwmet_pkg::A_PER:  per_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_EV1:  ev1_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_EV2:  ev2_r  <= i_avs_writedata[EW-1:0];
        pwmet_pkg::A_EV3:  ev3_r  <= i_avs_writedata[EW-1:0];
        pwmet_pkg::A_EV4:  ev4_r  <= i_avs_writedata[EW-1:0];
        pwmet_pkg::A_ADJA: adja_r <= i_avs_writedata[AJW-1:0];
        pwmet_pkg::A_ADJB: adjb_r <= i_avs_writedata[AJW-1:0];
        pwmet_pkg::A_SMP1: smp1_r <= i_avs_writedata[SW-1:0];
        pwmet_pkg::A_SMP2: smp2_r <= i_avs_writedata[SW-1:0];
        pwmet_pkg::A_PHS:  phs_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_BAB:  bab_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_BAE:  bae_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_BBB:  bbb_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_BBE:  bbe_r  <= i_avs_writedata[CW-1:0];
        pwmet_pkg::A_THU:  thu_r  <= i_avs_writedata[EW-1:0];
        pwmet_pkg::A_THL:  thl_r  <= i_avs_writedata[EW-1:0];
        default: ;
      endcase
    end
  end

  // =====================================================
  // Pin synchronisers
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      {sync_s1, sync_s2, sync_s3, clim_s1, clim_s2} <= '0;
    end else begin
      sync_s1 <= i_sync_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      clim_s1 <= i_clim;
      clim_s2 <= clim_s1;
    end
  end

  // =====================================================
  // Time base and shadows
  assign en        = ctrl_r[pwmet_pkg::B_EN];
  assign sync_rise = sync_s2 & ~sync_s3;
  assign per_end   = (cnt_r == per_sh);
  assign ld        = per_end | ~en;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cnt_r <= '0;
    end else if (!en || sync_rise) begin
      cnt_r <= '0;
    end else if (per_end) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // Loading only at wrap or while disabled avoids runt pulses on reprogramming
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      per_sh <= pwmet_pkg::RST_PER;
      {ev1_sh, ev2_sh, ev3_sh, ev4_sh, adja_sh, adjb_sh, phs_sh} <= '0;
    end else if (ld) begin
      per_sh  <= per_r;
      ev1_sh  <= ev1_r;
      ev2_sh  <= ev2_r;
      ev3_sh  <= ev3_r;
      ev4_sh  <= ev4_r;
      adja_sh <= adja_r;
      adjb_sh <= adjb_r;
      phs_sh  <= phs_r;
    end
  end

  // =====================================================
  // Mode selection with hysteresis
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      mode_r <= pwmet_pkg::PWMET_PWM;
    end else if (!ctrl_r[pwmet_pkg::B_AUTO]) begin
      mode_r <= pwmet_pkg::PWMET_PWM;
    end else begin
      case (mode_r)
        pwmet_pkg::PWMET_PWM:
          if (i_filter_duty > thu_r) mode_r <= pwmet_pkg::PWMET_PSH;
        pwmet_pkg::PWMET_PSH:
          if (i_filter_duty < thl_r) mode_r <= pwmet_pkg::PWMET_PWM;
        default: mode_r <= pwmet_pkg::PWMET_PWM;
      endcase
    end
  end
  // Closed loop: PWM mode modulates duty, phase shift mode the phase
  always_comb begin
    ev2_eff = ev2_sh;
    phs_eff = phs_sh;
    if (!ctrl_r[pwmet_pkg::B_OPEN]) begin
      if (mode_r == pwmet_pkg::PWMET_PSH) begin
        phs_eff = i_filter_duty[EW-1:FW];
      end else begin
        ev2_eff = i_filter_duty;
      end
    end
  end
  assign a_fall   = add_adj(ev2_eff, adja_sh);
  assign b_fall   = add_adj(ev4_sh, adjb_sh);
  assign b_fall_c = (ctrl_r[pwmet_pkg::B_BMAT] && trunc_r)
                  ? ev3_sh[EW-1:FW] + a_wid_r
                  : b_fall[EW-1:FW];
  assign clim_trip = ctrl_r[pwmet_pkg::B_CLIM] & o_output_a & clim_s2;

  // =====================================================
  // Outputs A and B, fall wins over rise
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_output_a <= 1'b0;
    end else if (!en || clim_trip) begin
      o_output_a <= 1'b0;
    end else if (cnt_r == a_fall[EW-1:FW]) begin
      o_output_a <= 1'b0;
    end else if (cnt_r == ev1_sh) begin
      o_output_a <= 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_output_b <= 1'b0;
    end else if (!en || cnt_r == b_fall_c) begin
      o_output_b <= 1'b0;
    end else if (cnt_r == ev3_sh[EW-1:FW]) begin
      o_output_b <= 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      trunc_r <= 1'b0;
      a_wid_r <= '0;
    end else if (clim_trip) begin
      trunc_r <= 1'b1;
      a_wid_r <= cnt_r - ev1_sh;
    end else if (ld) begin
      trunc_r <= 1'b0;
    end
  end
  // Fine phase selects for the delay-line edge placer
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      {o_a_fall_fine, o_b_rise_fine, o_b_fall_fine} <= '0;
    end else begin
      o_a_fall_fine <= a_fall[FW-1:0];
      o_b_rise_fine <= ev3_sh[FW-1:0];
      o_b_fall_fine <= b_fall[FW-1:0];
    end
  end

  // =====================================================
  // Sync, sample triggers and blanking
  // Sample counts are quarter-rate units, scaled up here
  assign os_step = per_sh >> ctrl_r[pwmet_pkg::B_OS +: 2];
  assign os_hit  = en && (os_left_r != 4'h0) && (cnt_r == nxt_smp_r);
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      nxt_smp_r <= '0;
      os_left_r <= 4'h0;
    end else if (os_hit) begin
      nxt_smp_r <= nxt_smp_r + os_step;
      os_left_r <= os_left_r - 4'h1;
    end else if (ld) begin
      nxt_smp_r <= q2f(smp1_r);
      os_left_r <= 4'h1 << ctrl_r[pwmet_pkg::B_OS +: 2];
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      {o_error_adc_trig, o_smp2_trig, o_sync_out} <= '0;
    end else begin
      o_error_adc_trig <= os_hit;
      o_smp2_trig <= en && (cnt_r == q2f(smp2_r));
      o_sync_out  <= en && (cnt_r == phs_eff);
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      {o_blank_a, o_blank_b} <= '0;
    end else if (!en) begin
      {o_blank_a, o_blank_b} <= '0;
    end else begin
      if (cnt_r == bae_r) o_blank_a <= 1'b0;
      else if (cnt_r == bab_r) o_blank_a <= 1'b1;
      if (cnt_r == bbe_r) o_blank_b <= 1'b0;
      else if (cnt_r == bbb_r) o_blank_b <= 1'b1;
    end
  end

  // =====================================================
  // Period interrupt divider
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      div_r        <= 8'h00;
      o_period_irq <= 1'b0;
      o_gadc_trig  <= 1'b0;
    end else begin
      o_period_irq <= 1'b0;
      o_gadc_trig  <= 1'b0;
      if (!en || ctrl_r[pwmet_pkg::B_DIV +: 4] == 4'h0) begin
        div_r <= 8'h00;
      end else if (per_end) begin
        if (div_r >= pwmet_pkg::div_count(ctrl_r[pwmet_pkg::B_DIV +: 4]))
        begin
          div_r        <= 8'h00;
          o_period_irq <= 1'b1;
          o_gadc_trig  <= 1'b1;
        end else begin
          div_r <= div_r + 8'h01;
        end
      end
    end
  end

  assign o_mode = mode_r;
  // =====================================================
  // Checks
  sequence s_trip;
    clim_trip ##1 !o_output_a;
  endsequence
  sequence s_wrap;
    per_end && en && !sync_rise ##1 cnt_r == '0;
  endsequence
  property p_wrap;
    per_end && en && !sync_rise |-> s_wrap;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_trip;
    clim_trip |-> s_trip ##1 !o_output_a;
  endproperty
  a_trip: assert property (p_trip) else $error("a not cut");
  property p_a_rise;
    $rose(o_output_a) |-> $past(cnt_r) == $past(ev1_sh);
  endproperty
  a_a_rise: assert property (p_a_rise) else $error("a rise");
  property p_a_fall;
    $fell(o_output_a) && $past(en) && !$past(clim_trip)
      |-> $past(cnt_r) == $past(a_fall[EW-1:FW]);
  endproperty
  a_a_fall: assert property (p_a_fall) else $error("a fall");
  property p_b_rise;
    $rose(o_output_b) |-> $past(cnt_r) == $past(ev3_sh[EW-1:FW]);
  endproperty
  a_b_rise: assert property (p_b_rise) else $error("b rise");
  property p_hold;
    !ld |=> $stable(per_sh) && $stable(ev2_sh) && $stable(ev4_sh);
  endproperty
  a_hold: assert property (p_hold) else $error("shadow moved");
  property p_irq;
    o_period_irq |-> $past(per_end) && o_gadc_trig;
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_hyst;
    mode_r == pwmet_pkg::PWMET_PWM && i_filter_duty <= thu_r
      |=> mode_r == pwmet_pkg::PWMET_PWM;
  endproperty
  a_hyst: assert property (p_hyst) else $error("mode flip");
  property p_os;
    ld && en && !os_hit |=> os_left_r != 4'h0 && os_left_r <= 4'h8;
  endproperty
  a_os: assert property (p_os) else $error("os count");
endmodule : pwmet_engine

// *** verif/pwmet_stage_model.sv ***
`timescale 1ns/1ps
// =====================================================
// Power stage stand-in: loop filter, sync pin, current sense
module pwmet_stage_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_output_a,
  input  wire logic        i_trip_en,
  input  wire logic        i_sync_req,
  input  wire logic [17:0] i_duty_set,
  output logic      [17:0] o_filter_duty,
  output logic             o_sync_in,
  output logic             o_clim
);
  int on_cnt;

  // One driver per output; all settle at the first edge, inside reset
  // Current ramps while A conducts; trips late so truncation is visible
  always @(posedge i_sys_clk) begin
    on_cnt <= i_output_a ? on_cnt + 1 : 0;
    o_clim <= i_trip_en && i_output_a && (on_cnt >= 7);
    o_sync_in <= i_sync_req;
    o_filter_duty <= i_duty_set;
  end
endmodule : pwmet_stage_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  logic        clk, resetn, rd_s, wr_s, wait_s, out_a, out_b, sync_out;
  logic        error_adc, smp2, blank_a, blank_b, irq, gadc, sync_in, clim;
  logic        trip_en, sync_req;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [17:0] duty, duty_set;
  logic [3:0]  fa, fbr, fbf;
  logic [1:0]  mode;
  int          bad_count, n_tests, cyc, hi, ha, per, k, d1;
  int          dcnt [16] = '{0, 0, 1, 3, 7, 15, 31, 47, 63, 79, 95, 127,
                             159, 191, 223, 255};

  pwmet_engine dut_u (.i_sys_clk(clk), .i_resetn(resetn),
    .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_s), .i_filter_duty(duty),
    .i_sync_in(sync_in), .i_clim(clim), .o_output_a(out_a),
    .o_output_b(out_b), .o_a_fall_fine(fa), .o_b_rise_fine(fbr),
    .o_b_fall_fine(fbf), .o_sync_out(sync_out), .o_error_adc_trig(error_adc),
    .o_smp2_trig(smp2), .o_blank_a(blank_a), .o_blank_b(blank_b),
    .o_period_irq(irq), .o_gadc_trig(gadc), .o_mode(mode));

  pwmet_stage_model stage_u (.i_sys_clk(clk), .i_output_a(out_a),
    .i_trip_en(trip_en), .i_sync_req(sync_req), .i_duty_set(duty_set),
    .o_filter_duty(duty), .o_sync_in(sync_in), .o_clim(clim));

  // =====================================================
  // Clock, timeout, verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("mismatches %0d, checks %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Irq sweep dominates; about 30k cycles expected
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      conclude();
    end
  end

  // =====================================================
  // Bus access, held until waitrequest sampled low
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= wr;
    rd_s <= !wr;
    do @(posedge clk); while (wait_s !== 1'b0);
    q = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : xfer

  function automatic logic [31:0] ctl(input int os, dv, lim, opn);
    ctl = 32'h1 | (32'(opn) << pwmet_pkg::B_OPEN)
        | (32'(os) << pwmet_pkg::B_OS) | (32'(dv) << pwmet_pkg::B_DIV)
        | (32'(lim) << pwmet_pkg::B_CLIM) | (32'(lim) << pwmet_pkg::B_BMAT);
  endfunction : ctl

  // High time and rise-to-rise interval of one output
  task automatic span(ref logic s, output int h, output int p);
    while (s !== 1'b0) @(posedge clk);
    while (s !== 1'b1) @(posedge clk);
    h = 0;
    while (s === 1'b1) begin
      @(posedge clk);
      h++;
    end
    p = h;
    while (s !== 1'b1) begin
      @(posedge clk);
      p++;
    end
  endtask : span

  // =====================================================
  // Tests
  initial begin
    resetn = 1'b0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    trip_en = 1'b0;
    sync_req = 1'b0;
    duty_set = 18'h3FFFF;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    xfer(0, pwmet_pkg::A_CTRL, 0);
    `CHK(q, 32'(pwmet_pkg::RST_CTRL));
    xfer(0, pwmet_pkg::A_PER, 0);
    `CHK(q, 32'(pwmet_pkg::RST_PER));
    xfer(0, 8'h48, 0);
    `CHK(q, 32'h0);
    `CHK(mode, 2'b01);
    xfer(1, pwmet_pkg::A_EV2, 32'hFFFFFFFF);
    xfer(0, pwmet_pkg::A_EV2, 0);
    `CHK(q, 32'h3FFFF);
    xfer(1, pwmet_pkg::A_EV1, 32'hFFFFFFFF);
    xfer(0, pwmet_pkg::A_EV1, 0);
    `CHK(q, 32'h3FFF);
    // Loaded while disabled, so shadows take the values at once
    xfer(1, pwmet_pkg::A_PER, 32'h9);
    xfer(1, pwmet_pkg::A_EV1, 32'h2);
    xfer(1, pwmet_pkg::A_EV2, 32'h53);
    xfer(1, pwmet_pkg::A_EV3, 32'h31);
    xfer(1, pwmet_pkg::A_EV4, 32'h75);
    xfer(1, pwmet_pkg::A_PHS, 32'h4);
    xfer(1, pwmet_pkg::A_BAB, 32'h3);
    xfer(1, pwmet_pkg::A_BAE, 32'h6);
    xfer(1, pwmet_pkg::A_BBB, 32'h5);
    xfer(1, pwmet_pkg::A_BBE, 32'h8);
    xfer(1, pwmet_pkg::A_SMP1, 32'h1);
    xfer(1, pwmet_pkg::A_SMP2, 32'h2);
    xfer(1, pwmet_pkg::A_CTRL, ctl(0, 1, 0, 1));
    span(out_a, hi, per);
    `CHK(hi, 3);
    `CHK(per, 10);
    `CHK(fa, 4'h3);
    span(out_b, hi, per);
    `CHK(hi, 4);
    `CHK({fbr, fbf}, 8'h15);
    span(sync_out, hi, per);
    `CHK(per, 10);
    span(blank_a, hi, per);
    `CHK(hi, 3);
    span(blank_b, hi, per);
    `CHK(hi, 3);
    `CHK(per, 10);
    span(error_adc, hi, per);
    `CHK(per, 10);
    span(irq, hi, per);
    `CHK(per, 10);
    `CHK(gadc, 1'b1);
    xfer(1, pwmet_pkg::A_ADJA, 32'h10);
    repeat (20) @(posedge clk);
    span(out_a, hi, per);
    `CHK(hi, 4);
    xfer(1, pwmet_pkg::A_ADJA, 32'hFFF0);
    repeat (20) @(posedge clk);
    span(out_a, hi, per);
    `CHK(hi, 2);
    xfer(1, pwmet_pkg::A_ADJA, 32'h0);
    duty_set <= 18'h70;
    xfer(1, pwmet_pkg::A_CTRL, ctl(0, 1, 0, 0));
    repeat (20) @(posedge clk);
    span(out_a, hi, per);
    `CHK(hi, 5);
    xfer(1, pwmet_pkg::A_CTRL, ctl(0, 1, 0, 1));
    span(out_a, hi, per);
    `CHK(hi, 3);
    xfer(1, pwmet_pkg::A_PER, 32'h3F);
    for (int os = 0; os < 4; os++) begin
      xfer(1, pwmet_pkg::A_CTRL, ctl(os, 1, 0, 1));
      repeat (130) @(posedge clk);
      k = 0;
      repeat (64) begin
        @(posedge clk);
        if (error_adc === 1'b1) k++;
      end
      `CHK(k, 1 << os);
      while (sync_out !== 1'b1) @(posedge clk);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (error_adc !== 1'b1);
      `CHK(k, (os == 0) ? 64 : (63 >> os));
    end
    span(smp2, hi, per);
    `CHK(per, 64);
    // Sync landing at two phases must give the same re-alignment
    for (int j = 0; j < 2; j++) begin
      while (sync_out !== 1'b1) @(posedge clk);
      repeat (10 + 20 * j) @(posedge clk);
      sync_req <= 1'b1;
      @(posedge clk);
      sync_req <= 1'b0;
      k = 0;
      while (sync_out !== 1'b1) begin
        @(posedge clk);
        k++;
      end
      if (j == 0) d1 = k;
    end
    `CHK(k, d1);
    xfer(1, pwmet_pkg::A_EV2, 32'h280);
    xfer(1, pwmet_pkg::A_EV3, 32'h2A0);
    xfer(1, pwmet_pkg::A_EV4, 32'h3C0);
    xfer(1, pwmet_pkg::A_CTRL, ctl(0, 1, 1, 1));
    trip_en <= 1'b1;
    repeat (130) @(posedge clk);
    span(out_a, ha, per);
    `CHK(ha inside {[9:14]}, 1'b1);
    span(out_b, hi, per);
    `CHK(hi, ha);
    trip_en <= 1'b0;
    xfer(1, pwmet_pkg::A_PER, 32'h9);
    for (int s = 1; s < 16; s++) begin
      xfer(1, pwmet_pkg::A_CTRL, ctl(0, s, 0, 1));
      span(irq, hi, per);
      `CHK(per, (dcnt[s] + 1) * 10);
      `CHK(gadc, 1'b1);
    end
    // Automatic mode change with a hysteresis band of 0x20 to 0x40
    xfer(1, pwmet_pkg::A_THU, 32'h40);
    xfer(1, pwmet_pkg::A_THL, 32'h20);
    duty_set <= 18'h60;
    xfer(1, pwmet_pkg::A_CTRL,
         ctl(0, 1, 0, 0) | (32'h1 << pwmet_pkg::B_AUTO));
    repeat (5) @(posedge clk);
    `CHK(mode, 2'b10);
    while (irq !== 1'b1) @(posedge clk);
    k = 0;
    while (sync_out !== 1'b1) begin
      @(posedge clk);
      k++;
    end
    `CHK(k, 7);
    duty_set <= 18'h30;
    repeat (5) @(posedge clk);
    `CHK(mode, 2'b10);
    duty_set <= 18'h10;
    repeat (5) @(posedge clk);
    `CHK(mode, 2'b01);
    duty_set <= 18'h30;
    repeat (5) @(posedge clk);
    `CHK(mode, 2'b01);
    conclude();
  end
endmodule : tb_top
